//--- include/battery_protect_defs.svh
`ifndef BATTERY_PROTECT_DEFS_SVH
`define BATTERY_PROTECT_DEFS_SVH

// register offsets
`define REG_STATUS   8'h00
`define REG_CTRL1    8'h04
`define REG_CTRL2    8'h05
`define REG_SHORT    8'h06
`define REG_OCD      8'h07
`define REG_VDLY     8'h08
`define REG_OVTRIP   8'h09
`define REG_UVTRIP   8'h0a
`define REG_CCCFG    8'h0b

// status bits
`define ST_READY     7
`define ST_UV        3
`define ST_OV        2
`define ST_SCD       1
`define ST_OCD       0
`define ST_MASK      8'h8f

// control bits and fields
`define C1_ADC_EN    4
`define C2_BYPASS    7
`define C2_CONT      6
`define C2_TRIG      5
`define C2_DSG       1
`define C2_CHG       0
`define SC_RANGE     7
`define SC_DLY       4:3
`define SC_THR       2:0
`define OC_DLY       6:4
`define OC_THR       3:0
`define UV_DLY       7:6
`define OV_DLY       5:4

// writable masks for registers with read-only bits
`define SC_WMASK     8'hbf
`define OC_WMASK     8'h7f
`define CC_WMASK     8'h3f

// reset values
`define ZERO_RST     8'h00
`define VDLY_RST     8'h08
`define OVTRIP_RST   8'hac
`define UVTRIP_RST   8'h97

// fixed framing of the 14-bit trip levels
`define OV_TOP       2'h2
`define OV_LOW       4'h8
`define UV_TOP       2'h1
`define UV_LOW       4'h0

// fault indices
`define FLT_OV       0
`define FLT_UV       1
`define FLT_OCD      2
`define FLT_SCD      3
`define FLT_N        4

// times in their own units
`define CLK_MHZ      32'd100
`define SCD_D0_US    32'd70
`define SCD_D1_US    32'd100
`define SCD_D2_US    32'd200
`define SCD_D3_US    32'd400
`define OCD_BASE_MS  32'd10
`define UV_D0_S      32'd1
`define UV_D1_S      32'd4
`define UV_D2_S      32'd8
`define UV_D3_S      32'd16
`define OV_D0_S      32'd1
`define OV_D1_S      32'd2
`define OV_D2_S      32'd4
`define OV_D3_S      32'd8
`define BYPASS_MS    32'd250
`define CC_CONV_MS   32'd250
`define CNT_W        32

`endif

//--- include/battery_protect_pkg.sv
`include "battery_protect_defs.svh"
package battery_protect_pkg;

  typedef enum logic [2:0] {
    CC_OFF    = 3'h1,
    CC_CONT   = 3'h2,
    CC_SINGLE = 3'h4
  } cc_state_t;

  typedef struct packed {
    logic [`CNT_W-1:0] cnt;
    logic              held;
    logic              trip;
  } qualify_state_t;

  typedef struct packed {
    logic [7:0]        status;
    logic [7:0]        ctrl2;
    logic [7:0]        short_cfg;
    logic [7:0]        ocd_cfg;
    logic [7:0]        vdly;
    logic [7:0]        high_cell_trip_level;
    logic [7:0]        low_cell_trip_level;
    logic [7:0]        counter_configuration;
    logic              adc_en;
    cc_state_t         cc_state;
    logic [`CNT_W-1:0] conv_cnt;
    logic              cc_active;
    logic [7:0]        rdata;
    logic [13:0]       hi_s1;
    logic [13:0]       hi_s2;
    logic [13:0]       lo_s1;
    logic [13:0]       lo_s2;
    logic [7:0]        sense_s1;
    logic [7:0]        sense_s2;
  } bank_state_t;

endpackage

//--- logic/fault_qualify.sv
`timescale 1ns/10ps
`default_nettype none
`include "battery_protect_defs.svh"
module fault_qualify (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cond,
  input  wire logic [`CNT_W-1:0] i_limit,
  output logic                   o_trip
);

  battery_protect_pkg::qualify_state_t st_reg;
  battery_protect_pkg::qualify_state_t st_next;

  // count while the condition holds, pulse once at the limit, rearm on drop
  always_comb begin
    st_next = st_reg;
    st_next.trip = 1'b0;
    if (!i_cond) begin
      st_next.cnt = '0;
      st_next.held = 1'b0;
    end else if (!st_reg.held) begin
      if (st_reg.cnt + `CNT_W'(1) >= i_limit) begin
        st_next.trip = 1'b1;
        st_next.held = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + `CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_trip = st_reg.trip;

  // a trip needs the condition present in the cycle before
  chk_trip_needs_cond: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_trip |-> $past(i_cond))
    else $error("trip without a persisting condition");

endmodule
`default_nettype wire

//--- logic/battery_protect_config.sv
// Behaviour
// - bypass bit replaces all four fault delays with about 250 ms
// - continuous enable runs counter nonstop and ignores single trigger
// - single trigger runs one 250 ms conversion, clears itself, sets ready
// - trigger accepted only with continuous off and ready clear
// - control bit 1 drives discharge output, bit 0 charge output
// - range bit doubles overcurrent and short thresholds together
// - short delay code selects 70, 100, 200 or 400 us
// - short threshold code picks mV level from range-dependent table
// - overcurrent delay is 10 ms doubled per code step
// - overcurrent threshold code picks mV level from range table
// - low cell delay code selects 1, 4, 8 or 16 s
// - high cell delay code selects 1, 2, 4 or 8 s
// - high trip byte framed as 10, byte, 1000 for comparison
// - high trip register resets to 0xac
// - low trip byte framed as 01, byte, 0000 for comparison
// - low trip register resets to 0x97
// - sample ready latches until host clears it
// - fault flags latch and clear only by writing one
// - converter enable gates high cell protection only; counter conversions run regardless
`timescale 1ns/10ps
`default_nettype none
`include "battery_protect_defs.svh"
module battery_protect_config #(
  parameter logic [`CNT_W-1:0] US_CYC      = `CLK_MHZ,
  parameter logic [`CNT_W-1:0] MS_CYC      = `CLK_MHZ * 32'd1000,
  parameter logic [`CNT_W-1:0] S_CYC       = `CLK_MHZ * 32'd1000000,
  parameter logic [`CNT_W-1:0] BYPASS_CYC  = `BYPASS_MS * `CLK_MHZ * 32'd1000,
  parameter logic [`CNT_W-1:0] CC_CONV_CYC = `CC_CONV_MS * `CLK_MHZ * 32'd1000
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic [13:0] i_cell_high_code,
  input  wire logic [13:0] i_cell_low_code,
  input  wire logic [7:0]  i_sense_mv,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_charge_driver,
  output logic             o_discharge_driver,
  output logic             o_cc_active,
  output logic             o_adc_active
);

  localparam logic [7:0] SCD_HI [8] = '{8'h2c, 8'h43, 8'h59, 8'h6f,
                                        8'h85, 8'h9b, 8'hb2, 8'hc8};
  localparam logic [7:0] SCD_LO [8] = '{8'h16, 8'h21, 8'h2c, 8'h38,
                                        8'h43, 8'h4e, 8'h59, 8'h64};
  localparam logic [7:0] OCD_HI [16] = '{8'h11, 8'h16, 8'h1c, 8'h21,
                                         8'h27, 8'h2c, 8'h32, 8'h38,
                                         8'h3d, 8'h43, 8'h48, 8'h4e,
                                         8'h53, 8'h59, 8'h5e, 8'h64};
  localparam logic [7:0] OCD_LO [16] = '{8'h08, 8'h0b, 8'h0e, 8'h11,
                                         8'h13, 8'h16, 8'h19, 8'h1c,
                                         8'h1f, 8'h21, 8'h24, 8'h27,
                                         8'h2a, 8'h2c, 8'h2f, 8'h32};

  battery_protect_pkg::bank_state_t st_reg;
  battery_protect_pkg::bank_state_t st_next;

  logic              flt_cond  [`FLT_N];
  logic [`CNT_W-1:0] flt_limit [`FLT_N];
  logic [`FLT_N-1:0] flt_trip;
  logic              wr_status;
  logic              wr_ctrl2;
  logic              trig_ok;
  logic              conv_end;
  logic [7:0]        scd_mv;
  logic [7:0]        ocd_mv;

  // short circuit delay in cycles
  function automatic logic [`CNT_W-1:0] scd_delay(input logic [1:0] code);
    logic [`CNT_W-1:0] us;
    us = `SCD_D0_US;
    unique case (code)
      2'h0: us = `SCD_D0_US;
      2'h1: us = `SCD_D1_US;
      2'h2: us = `SCD_D2_US;
      2'h3: us = `SCD_D3_US;
    endcase
    return `CNT_W'(us * US_CYC);
  endfunction

  // low cell delay in cycles
  function automatic logic [`CNT_W-1:0] uv_delay(input logic [1:0] code);
    logic [`CNT_W-1:0] s;
    s = `UV_D0_S;
    unique case (code)
      2'h0: s = `UV_D0_S;
      2'h1: s = `UV_D1_S;
      2'h2: s = `UV_D2_S;
      2'h3: s = `UV_D3_S;
    endcase
    return `CNT_W'(s * S_CYC);
  endfunction

  // high cell delay in cycles
  function automatic logic [`CNT_W-1:0] ov_delay(input logic [1:0] code);
    logic [`CNT_W-1:0] s;
    s = `OV_D0_S;
    unique case (code)
      2'h0: s = `OV_D0_S;
      2'h1: s = `OV_D1_S;
      2'h2: s = `OV_D2_S;
      2'h3: s = `OV_D3_S;
    endcase
    return `CNT_W'(s * S_CYC);
  endfunction

  // thresholds, upper column is the doubled range
  always_comb begin
    scd_mv = st_reg.short_cfg[`SC_RANGE] ?
             SCD_HI[st_reg.short_cfg[`SC_THR]] :
             SCD_LO[st_reg.short_cfg[`SC_THR]];
    ocd_mv = st_reg.short_cfg[`SC_RANGE] ?
             OCD_HI[st_reg.ocd_cfg[`OC_THR]] :
             OCD_LO[st_reg.ocd_cfg[`OC_THR]];
  end

  // fault conditions on the synchronised measurements
  always_comb begin
    flt_cond[`FLT_OV]  = st_reg.adc_en &&
      (st_reg.hi_s2 >= {`OV_TOP, st_reg.high_cell_trip_level, `OV_LOW});
    flt_cond[`FLT_UV]  =
      (st_reg.lo_s2 <= {`UV_TOP, st_reg.low_cell_trip_level, `UV_LOW});
    flt_cond[`FLT_OCD] = (st_reg.sense_s2 >= ocd_mv);
    flt_cond[`FLT_SCD] = (st_reg.sense_s2 >= scd_mv);
  end

  // delay per fault, bypass overrides all four
  always_comb begin
    if (st_reg.ctrl2[`C2_BYPASS]) begin
      flt_limit[`FLT_OV]  = BYPASS_CYC;
      flt_limit[`FLT_UV]  = BYPASS_CYC;
      flt_limit[`FLT_OCD] = BYPASS_CYC;
      flt_limit[`FLT_SCD] = BYPASS_CYC;
    end else begin
      flt_limit[`FLT_OV]  = ov_delay(st_reg.vdly[`OV_DLY]);
      flt_limit[`FLT_UV]  = uv_delay(st_reg.vdly[`UV_DLY]);
      flt_limit[`FLT_OCD] = `CNT_W'((`OCD_BASE_MS * MS_CYC)
                            << st_reg.ocd_cfg[`OC_DLY]);
      flt_limit[`FLT_SCD] =
        scd_delay(st_reg.short_cfg[`SC_DLY]);
    end
  end

  // one persistence timer per fault
  genvar gi;
  generate
    for (gi = 0; gi < `FLT_N; gi++) begin : g_flt
      fault_qualify u_qualify (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_cond  (flt_cond[gi]),
        .i_limit (flt_limit[gi]),
        .o_trip  (flt_trip[gi])
      );
    end
  endgenerate

  // decode and conversion timing
  always_comb begin
    wr_status = i_reg_wr && (i_reg_addr == `REG_STATUS);
    wr_ctrl2  = i_reg_wr && (i_reg_addr == `REG_CTRL2);
    trig_ok   = i_reg_wdata[`C2_TRIG] && !i_reg_wdata[`C2_CONT] &&
                !st_reg.status[`ST_READY];
    conv_end  = (st_reg.cc_state != battery_protect_pkg::CC_OFF) &&
                (st_reg.conv_cnt + `CNT_W'(1) >= CC_CONV_CYC);
  end

  // next state: host writes first, hardware events after so sets win
  always_comb begin
    st_next = st_reg;
    // measurements arrive from the analog side, two stages before use;
    // codes change slowly so a torn word only shifts one sample
    st_next.hi_s1    = i_cell_high_code;
    st_next.hi_s2    = st_reg.hi_s1;
    st_next.lo_s1    = i_cell_low_code;
    st_next.lo_s2    = st_reg.lo_s1;
    st_next.sense_s1 = i_sense_mv;
    st_next.sense_s2 = st_reg.sense_s1;

    // register writes
    if (wr_status) begin
      st_next.status = st_reg.status &
                       ~(i_reg_wdata & `ST_MASK);
    end
    if (wr_ctrl2) begin
      st_next.ctrl2 = i_reg_wdata;
      // a trigger write of zero never cancels a pending reading
      st_next.ctrl2[`C2_TRIG] =
        st_reg.ctrl2[`C2_TRIG] | trig_ok;
    end
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `REG_CTRL1:  st_next.adc_en = i_reg_wdata[`C1_ADC_EN];
        `REG_SHORT:  st_next.short_cfg = i_reg_wdata & `SC_WMASK;
        `REG_OCD:    st_next.ocd_cfg   = i_reg_wdata & `OC_WMASK;
        `REG_VDLY:   st_next.vdly      = i_reg_wdata;
        `REG_OVTRIP: st_next.high_cell_trip_level   = i_reg_wdata;
        `REG_UVTRIP: st_next.low_cell_trip_level   = i_reg_wdata;
        `REG_CCCFG:  st_next.counter_configuration    = i_reg_wdata & `CC_WMASK;
        default: ;
      endcase
    end

    // qualified faults latch a flag and open the affected driver
    if (flt_trip[`FLT_OV]) begin
      st_next.status[`ST_OV]  = 1'b1;
      st_next.ctrl2[`C2_CHG]  = 1'b0;
    end
    if (flt_trip[`FLT_UV]) begin
      st_next.status[`ST_UV]  = 1'b1;
      st_next.ctrl2[`C2_DSG]  = 1'b0;
    end
    if (flt_trip[`FLT_OCD]) begin
      st_next.status[`ST_OCD] = 1'b1;
      st_next.ctrl2[`C2_DSG]  = 1'b0;
    end
    if (flt_trip[`FLT_SCD]) begin
      st_next.status[`ST_SCD] = 1'b1;
      st_next.ctrl2[`C2_DSG]  = 1'b0;
    end

    // coulomb counter sequencing
    unique case (st_reg.cc_state)
      battery_protect_pkg::CC_OFF: begin
        st_next.conv_cnt = '0;
        if (st_reg.ctrl2[`C2_CONT]) begin
          st_next.cc_state = battery_protect_pkg::CC_CONT;
        end else if (st_reg.ctrl2[`C2_TRIG]) begin
          st_next.cc_state = battery_protect_pkg::CC_SINGLE;
        end
      end
      battery_protect_pkg::CC_CONT: begin
        st_next.conv_cnt = conv_end ? '0 : st_reg.conv_cnt + `CNT_W'(1);
        if (conv_end) begin
          st_next.status[`ST_READY] = 1'b1;
        end
        if (!st_reg.ctrl2[`C2_CONT]) begin
          st_next.cc_state = battery_protect_pkg::CC_OFF;
          st_next.conv_cnt = '0;
        end
      end
      battery_protect_pkg::CC_SINGLE: begin
        st_next.conv_cnt = st_reg.conv_cnt + `CNT_W'(1);
        if (st_reg.ctrl2[`C2_CONT]) begin
          st_next.cc_state = battery_protect_pkg::CC_CONT;
          st_next.conv_cnt = '0;
        end else if (conv_end) begin
          st_next.ctrl2[`C2_TRIG]   = 1'b0;
          st_next.status[`ST_READY] = 1'b1;
          st_next.cc_state = battery_protect_pkg::CC_OFF;
          st_next.conv_cnt = '0;
        end
      end
      default: begin
        st_next.cc_state = battery_protect_pkg::CC_OFF;
        st_next.conv_cnt = '0;
      end
    endcase
    st_next.cc_active = (st_next.cc_state != battery_protect_pkg::CC_OFF);

    // read data registered, unmapped offsets answer zero
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `REG_STATUS: st_next.rdata = st_reg.status & `ST_MASK;
        `REG_CTRL1:  st_next.rdata = {3'h0, st_reg.adc_en, 4'h0};
        `REG_CTRL2:  st_next.rdata = st_reg.ctrl2;
        `REG_SHORT:  st_next.rdata = st_reg.short_cfg;
        `REG_OCD:    st_next.rdata = st_reg.ocd_cfg;
        `REG_VDLY:   st_next.rdata = st_reg.vdly;
        `REG_OVTRIP: st_next.rdata = st_reg.high_cell_trip_level;
        `REG_UVTRIP: st_next.rdata = st_reg.low_cell_trip_level;
        `REG_CCCFG:  st_next.rdata = st_reg.counter_configuration;
        default:     st_next.rdata = `ZERO_RST;
      endcase
    end
  end

  // state register; debug nibble of the delay register comes up set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg           <= '0;
      st_reg.vdly      <= `VDLY_RST;
      st_reg.high_cell_trip_level   <= `OVTRIP_RST;
      st_reg.low_cell_trip_level   <= `UVTRIP_RST;
      st_reg.cc_state  <= battery_protect_pkg::CC_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_reg_rdata        = st_reg.rdata;
  assign o_charge_driver    = st_reg.ctrl2[`C2_CHG];
  assign o_discharge_driver = st_reg.ctrl2[`C2_DSG];
  assign o_cc_active        = st_reg.cc_active;
  assign o_adc_active       = st_reg.adc_en;

  chk_driver_follows_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr_ctrl2 && (flt_trip == '0)) |=>
      (o_charge_driver == $past(i_reg_wdata[`C2_CHG])) &&
      (o_discharge_driver == $past(i_reg_wdata[`C2_DSG])))
    else $error("driver outputs do not follow control write");

  chk_high_trip_cuts: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flt_trip[`FLT_OV] |=> !o_charge_driver && st_reg.status[`ST_OV])
    else $error("high cell fault left charge driver on");

  chk_low_trip_cuts: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (flt_trip[`FLT_UV] || flt_trip[`FLT_OCD] || flt_trip[`FLT_SCD]) |=>
      !o_discharge_driver)
    else $error("discharge fault left discharge driver on");

  chk_set_beats_clear: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (flt_trip[`FLT_UV] && wr_status && i_reg_wdata[`ST_UV]) |=>
      st_reg.status[`ST_UV])
    else $error("fault flag lost to simultaneous clear");

  chk_flag_sticky: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st_reg.status[`ST_READY] && !(wr_status && i_reg_wdata[`ST_READY]))
      |=> st_reg.status[`ST_READY])
    else $error("sample ready dropped without a host clear");

  chk_trigger_refused: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr_ctrl2 && !st_reg.ctrl2[`C2_TRIG] &&
     (i_reg_wdata[`C2_CONT] || st_reg.status[`ST_READY])) |=>
      !st_reg.ctrl2[`C2_TRIG])
    else $error("single trigger taken while not allowed");

  chk_single_ends: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st_reg.cc_state == battery_protect_pkg::CC_SINGLE && conv_end &&
     !st_reg.ctrl2[`C2_CONT]) |=>
      !st_reg.ctrl2[`C2_TRIG] && st_reg.status[`ST_READY] && !o_cc_active)
    else $error("single reading did not finish cleanly");

  chk_high_needs_adc: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !st_reg.adc_en |-> !flt_cond[`FLT_OV])
    else $error("high cell check active with converter off");

  chk_bypass_delay: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st_reg.ctrl2[`C2_BYPASS] |-> (flt_limit[`FLT_UV] == BYPASS_CYC) &&
      (flt_limit[`FLT_SCD] == BYPASS_CYC))
    else $error("bypass did not replace fault delays");

endmodule
`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "battery_protect_defs.svh"
module host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // idle bus, strobes low from time zero
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'hff;
    o_wdata = 8'h00;
  end

  // one-cycle write; released lines show the inverse, not a stale value
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= (a == `REG_VDLY) ? {v[7:4], 4'h8} : v;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~v;
  endtask

  // data lands at the edge that takes the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 v = i_rdata;
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "battery_protect_defs.svh"
module tb;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  localparam int NROW = 12;

  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  rdata;
  logic [13:0] high_code = 14'h0000;
  logic [13:0] low_code = 14'h3fff;
  logic [7:0]  sense_mv = 8'h00;
  logic        charge_on;
  logic        discharge_on;
  logic        cc_act;
  logic        adc_act;
  logic [7:0]  outs;
  int          err_count = 0;
  int          n_tests = 0;

  // plain rows: reset values, write masks, unmapped offset
  row_t rows [NROW] = '{
    '{8'h09, 1'b0, 8'h00, 8'hac},
    '{8'h0a, 1'b0, 8'h00, 8'h97},
    '{8'h08, 1'b0, 8'h00, 8'h08},
    '{8'h05, 1'b0, 8'h00, 8'h00},
    '{8'h06, 1'b1, 8'hff, 8'hbf},
    '{8'h07, 1'b1, 8'hff, 8'h7f},
    '{8'h0b, 1'b1, 8'hff, 8'h3f},
    '{8'h0b, 1'b1, 8'h19, 8'h19},
    '{8'h08, 1'b1, 8'hc0, 8'hc8},
    '{8'h09, 1'b1, 8'h5a, 8'h5a},
    '{8'h0a, 1'b1, 8'ha5, 8'ha5},
    '{8'h0c, 1'b1, 8'h55, 8'h00}
  };

  always #5 i_clk = ~i_clk;
  assign outs = {4'h0, charge_on, discharge_on, cc_act, adc_act};

  host_model u_host_model (
    .i_clk   (i_clk),
    .i_rdata (rdata),
    .o_wr    (reg_wr),
    .o_rd    (reg_rd),
    .o_addr  (reg_addr),
    .o_wdata (reg_wdata)
  );

  // short counts so every delay fits a quick run
  battery_protect_config #(
    .US_CYC      (32'd1),
    .MS_CYC      (32'd4),
    .S_CYC       (32'd10),
    .BYPASS_CYC  (32'd6),
    .CC_CONV_CYC (32'd8)
  ) u_battery_protect_config (
    .i_clk              (i_clk),
    .i_rst              (i_rst),
    .i_reg_wr           (reg_wr),
    .i_reg_rd           (reg_rd),
    .i_reg_addr         (reg_addr),
    .i_reg_wdata        (reg_wdata),
    .i_cell_high_code   (high_code),
    .i_cell_low_code    (low_code),
    .i_sense_mv         (sense_mv),
    .o_reg_rdata        (rdata),
    .o_charge_driver    (charge_on),
    .o_discharge_driver (discharge_on),
    .o_cc_active        (cc_act),
    .o_adc_active       (adc_act)
  );

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    n_tests++;
    if (act !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, act, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host_model.read(a, v);
    chk(v, exp);
  endtask

  // bounded status poll; running out ends the run
  task automatic poll(input logic [7:0] m, input logic [7:0] exp,
                      input int lim);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < lim; i++) begin
      u_host_model.read(`REG_STATUS, v);
      if ((v & m) === exp) return;
    end
    chk(v & m, exp);
    print_verdict();
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(outs, 8'h00);
    for (int i = 0; i < NROW; i++) begin
      if (rows[i].wr) u_host_model.write(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // driver enables
    u_host_model.write(`REG_CTRL2, 8'h03);
    #1 chk(outs, 8'h0c);
    u_host_model.write(`REG_CTRL2, 8'h02);
    #1 chk(outs, 8'h04);
    u_host_model.write(`REG_CTRL2, 8'h03);
    // low cell one code above the framed level, then at it
    @(posedge i_clk) low_code <= 14'h1a51;
    repeat (30) @(posedge i_clk);
    #1 chk(outs, 8'h0c);
    @(posedge i_clk) low_code <= 14'h1a50;
    // longest low cell code is 160 cycles here, so nothing yet at 100
    repeat (100) @(posedge i_clk);
    rd_chk(`REG_STATUS, 8'h00);
    poll(8'h08, 8'h08, 40);
    #1 chk(outs, 8'h08);
    @(posedge i_clk) low_code <= 14'h3fff;
    u_host_model.write(`REG_STATUS, 8'h00);
    rd_chk(`REG_STATUS, 8'h08);
    u_host_model.write(`REG_STATUS, 8'h08);
    rd_chk(`REG_STATUS, 8'h00);
    // high cell ignored until the converter runs
    u_host_model.write(`REG_CTRL2, 8'h03);
    @(posedge i_clk) high_code <= 14'h25a8;
    repeat (30) @(posedge i_clk);
    #1 chk(outs, 8'h0c);
    u_host_model.write(`REG_CTRL1, 8'h10);
    poll(8'h04, 8'h04, 20);
    #1 chk(outs, 8'h05);
    @(posedge i_clk) high_code <= 14'h0000;
    u_host_model.write(`REG_STATUS, 8'h04);
    // short at exactly 100 mV, 70-cycle delay, slow overcurrent
    u_host_model.write(`REG_CTRL2, 8'h03);
    u_host_model.write(`REG_SHORT, 8'h07);
    u_host_model.write(`REG_OCD, 8'h70);
    @(posedge i_clk) sense_mv <= 8'h64;
    repeat (60) @(posedge i_clk);
    rd_chk(`REG_STATUS, 8'h00);
    poll(8'h03, 8'h02, 20);
    #1 chk(outs, 8'h09);
    // bypass shortens both the overcurrent and the short delays
    @(posedge i_clk) sense_mv <= 8'h00;
    u_host_model.write(`REG_CTRL2, 8'h83);
    u_host_model.write(`REG_STATUS, 8'h03);
    @(posedge i_clk) sense_mv <= 8'h64;
    poll(8'h03, 8'h03, 8);
    // upper range: 150 mV under short level, over overcurrent level
    @(posedge i_clk) sense_mv <= 8'h00;
    u_host_model.write(`REG_SHORT, 8'h87);
    u_host_model.write(`REG_STATUS, 8'h03);
    @(posedge i_clk) sense_mv <= 8'h96;
    poll(8'h01, 8'h01, 8);
    repeat (10) @(posedge i_clk);
    rd_chk(`REG_STATUS, 8'h01);
    // single reading, then a refused second trigger
    @(posedge i_clk) sense_mv <= 8'h00;
    u_host_model.write(`REG_STATUS, 8'h8f);
    u_host_model.write(`REG_CTRL2, 8'h20);
    @(posedge i_clk);
    #1 chk(outs, 8'h03);
    poll(8'h80, 8'h80, 10);
    rd_chk(`REG_CTRL2, 8'h00);
    #1 chk(outs, 8'h01);
    u_host_model.write(`REG_CTRL2, 8'h20);
    rd_chk(`REG_CTRL2, 8'h00);
    #1 chk(outs, 8'h01);
    repeat (12) @(posedge i_clk);
    rd_chk(`REG_STATUS, 8'h80);
    u_host_model.write(`REG_STATUS, 8'h80);
    rd_chk(`REG_STATUS, 8'h00);
    // continuous mode swallows the trigger and keeps running
    u_host_model.write(`REG_CTRL2, 8'h60);
    rd_chk(`REG_CTRL2, 8'h40);
    poll(8'h80, 8'h80, 10);
    repeat (20) @(posedge i_clk);
    #1 chk(outs, 8'h03);
    rd_chk(`REG_STATUS, 8'h80);
    // second reset in mid-run
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(outs, 8'h00);
    rd_chk(`REG_CTRL2, 8'h00);
    rd_chk(`REG_OVTRIP, `OVTRIP_RST);
    print_verdict();
  end
endmodule
`default_nettype wire
